// ---- tb/hlpt_ers_src.sv ----
`timescale 1ns/1ps
`default_nettype none

module hlpt_ers_src (
    // clock and reset
    input  wire logic clk_i,
    input  wire logic rst_i,
    // wanted level and driven signal
    input  wire logic want_i,
    output logic      sig_o
);
    logic [3:0] gap_q;

    // follow wanted level, keeping triggers spaced
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            gap_q <= 4'hF;
            sig_o <= 1'b0;
        end else if (want_i != sig_o && gap_q >= 4'h6) begin
            sig_o <= want_i;
            gap_q <= 4'h0;
        end else if (gap_q != 4'hF) begin
            gap_q <= gap_q + 4'h1;
        end
    end
endmodule

`default_nettype wire

// ---- tb/hlpt_timer_asserts.sv ----
`timescale 1ns/1ps
`default_nettype none

module hlpt_timer_asserts
    import hlpt_pkg::*;
(
    // clock and reset
    input  wire logic             clk_i,
    input  wire logic             rst_i,
    // bus
    input  wire logic             wb_cyc_i,
    input  wire logic             wb_stb_i,
    input  wire logic             wb_we_i,
    input  wire logic [ADR_W-1:0] wb_adr_i,
    input  wire logic [WB_W-1:0]  wb_dat_o,
    input  wire logic             wb_ack_o,
    // timer
    input  wire logic [CNT_W-1:0] timer_count_o,
    input  wire logic             period_match_o,
    input  wire logic             irq_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    // ------------------------------------------------------------
    // bus and timer properties
    // ------------------------------------------------------------
    sequence bus_req;
        wb_cyc_i && wb_stb_i && !wb_ack_o;
    endsequence
    sequence cnt_wr;
        $past(wb_ack_o && wb_we_i && wb_adr_i == ADR_COUNT);
    endsequence

    ack_answer_a: assert property (bus_req |=> wb_ack_o) else $error("ack missing");
    ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack too long");
    ack_cause_a: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i && !wb_ack_o))
        else $error("ack without request");
    dat_upper_a: assert property (wb_ack_o |-> wb_dat_o[31:8] == 24'h000000)
        else $error("read upper bits set");
    dat_hold_a: assert property (!wb_cyc_i |=> $stable(wb_dat_o)) else $error("read data moved");
    reset_vals_a: assert property ($fell(rst_i) |-> timer_count_o == CNT_ZERO && !irq_o
        && !period_match_o && !wb_ack_o) else $error("bad reset state");
    count_step_a: assert property ($changed(timer_count_o) |->
        (timer_count_o == $past(timer_count_o) + 8'h01 || timer_count_o == CNT_ZERO) or cnt_wr)
        else $error("count jumped");
    match_zero_a: assert property (period_match_o |-> timer_count_o == CNT_ZERO
        || $past(timer_count_o) == CNT_ZERO) else $error("match without wrap");
endmodule

bind hlpt_timer hlpt_timer_asserts hlpt_timer_asserts_i (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .timer_count_o(timer_count_o), .period_match_o(period_match_o), .irq_o(irq_o));

`default_nettype wire

// ---- tb/hlpt_timer_tb_top.sv ----
`timescale 1ns/1ps
`default_nettype none

module hlpt_timer_tb_top
    import hlpt_pkg::*;
;
    logic             clk_i = 1'b0;
    logic             rst_i = 1'b1;
    logic             cyc = 1'b0;
    logic             stb = 1'b0;
    logic             we = 1'b0;
    logic             want = 1'b0;
    logic             frz = 1'b0;
    logic [ADR_W-1:0] adr = 8'h00;
    logic [WB_W-1:0]  wdat = 32'h00000000;
    logic [WB_W-1:0]  rdat;
    logic [WB_W-1:0]  q;
    logic [CNT_W-1:0] cnt;
    logic [CNT_W-1:0] v;
    logic             ack;
    logic             ers;
    logic             match;
    logic             irq;
    int               error_cnt = 0;
    int               n_tests = 0;
    int               m;

    always #12.5 clk_i = ~clk_i;

    hlpt_timer hlpt_timer_i (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(wdat), .wb_dat_o(rdat),
        .wb_ack_o(ack), .ext_reset_signal_i(ers), .freeze_i(frz), .timer_count_o(cnt),
        .period_match_o(match), .irq_o(irq));
    hlpt_ers_src hlpt_ers_src_i (.clk_i(clk_i), .rst_i(rst_i), .want_i(want), .sig_o(ers));

    // ------------------------------------------------------------
    // shared tasks
    // ------------------------------------------------------------
    task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
        n_tests++;
        if (s !== e) begin
            error_cnt++;
            $display("Error %s expected %h seen %h", n, e, s);
        end
    endtask
    task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_i);
        {cyc, stb, we, adr, wdat} <= {1'b1, 1'b1, w, a, 24'h000000, d};
        @(posedge clk_i);
        while (ack !== 1'b1) @(posedge clk_i);
        q = rdat;
        {cyc, stb} <= 2'b00;
    endtask
    task automatic rdc(input string n, input logic [7:0] a, input logic [7:0] e);
        bus(1'b0, a, 8'h00);
        chk(n, q, {24'h000000, e});
    endtask
    task automatic tick(input int k);
        repeat (k) @(posedge clk_i);
    endtask
    task automatic arm(input logic [MODE_W-1:0] md, input logic [7:0] p, input logic [7:0] c);
        bus(1'b1, ADR_CTRL, 8'h00);
        bus(1'b1, ADR_MODE, {3'h0, md});
        bus(1'b1, ADR_PERIOD, p);
        bus(1'b1, ADR_COUNT, 8'h00);
        bus(1'b1, ADR_CTRL, c);
    endtask
    task automatic count_matches(input int k);
        m = 0;
        repeat (k) begin
            @(posedge clk_i);
            if (match === 1'b1) m++;
            if (irq === 1'b1) break;
        end
    endtask

    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic t_regs;
        rdc("count", ADR_COUNT, 8'h00);
        rdc("period", ADR_PERIOD, 8'hFF);
        rdc("ctrl", ADR_CTRL, 8'h00);
        rdc("unmapped", 8'h20, 8'h00);
        $display("reset values done");
    endtask
    task automatic t_swgate;
        arm(MODE_SW_GATE, 8'h02, 8'h80);
        repeat (10) if (cnt !== 8'h02) @(posedge clk_i);
        @(posedge clk_i);
        chk("wrap", cnt, 32'h0);
        @(posedge clk_i);
        chk("after wrap", cnt, 32'h1);
        bus(1'b1, ADR_CTRL, 8'h00);
        tick(2);
        v = cnt;
        tick(4);
        chk("stopped", cnt, {24'h0, v});
        $display("software gate done");
    endtask
    task automatic t_gate;
        for (int g = 0; g < 2; g++) begin
            want <= g[0];
            arm(g[0] ? MODE_HW_GATEL : MODE_HW_GATEH, 8'hFF, 8'h80);
            tick(8);
            v = cnt;
            tick(4);
            chk("gated", cnt, {24'h0, v});
            want <= !g[0];
            tick(8);
            v = cnt;
            tick(4);
            chk("open", cnt, {24'h0, v + 8'h04});
            want <= 1'b0;
            tick(8);
        end
        $display("hardware gate done");
    endtask
    task automatic t_limit;
        arm(MODE_LIM_RISE, 8'hFF, 8'h80);
        tick(30);
        want <= 1'b1;
        tick(7);
        chk("early reset", cnt < 8'h06, 32'h1);
        want <= 1'b0;
        tick(8);
        arm(MODE_LVL_HI, 8'hFF, 8'h80);
        want <= 1'b1;
        tick(8);
        chk("level hold", cnt, 32'h0);
        want <= 1'b0;
        $display("edge limit done");
    endtask
    task automatic t_oneshot;
        arm(MODE_OS_SW, 8'h03, 8'h80);
        repeat (20) if (match !== 1'b1) @(posedge clk_i);
        tick(2);
        rdc("run cleared", ADR_CTRL, 8'h00);
        chk("held zero", cnt, 32'h0);
        tick(5);
        chk("no restart", cnt, 32'h0);
        $display("one-shot done");
    endtask
    task automatic t_edge;
        arm(MODE_OS_RISE, 8'h08, 8'h80);
        tick(6);
        chk("wait edge", cnt, 32'h0);
        want <= 1'b1;
        count_matches(16);
        chk("edge shot", m, 32'h1);
        rdc("shot run", ADR_CTRL, 8'h00);
        arm(MODE_MS_FALL, 8'h20, 8'h80);
        frz <= 1'b1;
        want <= 1'b0;
        tick(7);
        want <= 1'b1;
        tick(7);
        frz <= 1'b0;
        tick(6);
        chk("frozen", cnt, 32'h0);
        want <= 1'b0;
        count_matches(40);
        chk("mono shot", m, 32'h1);
        rdc("mono run", ADR_CTRL, 8'h80);
        chk("mono zero", cnt, 32'h0);
        $display("edge start done");
    endtask
    task automatic t_irq;
        bus(1'b1, ADR_IRQ, 8'h03);
        arm(MODE_SW_GATE, 8'h05, 8'h83);
        count_matches(60);
        chk("matches per irq", m, 32'h4);
        bus(1'b1, ADR_IRQ, 8'h00);
        tick(2);
        chk("irq masked", irq, 1'b0);
        rdc("flag", ADR_IRQ, 8'h02);
        bus(1'b1, ADR_CTRL, 8'h00);
        $display("interrupt done");
    endtask
    task automatic t_reserved;
        arm(5'h14, 8'h05, 8'h80);
        count_matches(12);
        chk("reserved match", m, 32'h0);
        chk("reserved count", cnt, 32'h0);
        bus(1'b1, ADR_CTRL, 8'h00);
        $display("reserved done");
    endtask

    task automatic report_and_stop;
        $display("comparisons %0d mismatches %0d", n_tests, error_cnt);
        if (error_cnt == 0 && n_tests > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask

    // main sequence
    initial begin
        tick(4);
        rst_i <= 1'b0;
        t_regs();
        t_swgate();
        t_gate();
        t_limit();
        t_oneshot();
        t_edge();
        t_irq();
        t_reserved();
        report_and_stop();
    end

    // hang guard, well beyond the expected run
    initial begin
        #500000;
        error_cnt++;
        report_and_stop();
    end
endmodule

`default_nettype wire

// ---- verilog/hlpt_ers_delay.sv ----
`timescale 1ns/1ps
`default_nettype none

module hlpt_ers_delay
    import hlpt_pkg::*;
(
    // clock and reset
    input  wire logic clk_i,
    input  wire logic rst_i,
    // external signal
    input  wire logic ext_reset_signal_i,
    input  wire logic freeze_i,
    // delayed level and edges
    output logic      level_o,
    output logic      rise_o,
    output logic      fall_o
);

    logic stage1_q;
    logic stage2_q;
    logic prev_q;

    // two-clock delay line; frozen in debug so no new edge is seen, an edge already present stays asserted
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            stage1_q <= 1'b0;
            stage2_q <= 1'b0;
            prev_q   <= 1'b0;
        end else if (!freeze_i) begin
            stage1_q <= ext_reset_signal_i;
            stage2_q <= stage1_q;
            prev_q   <= stage2_q;
        end
    end

    // edge detect on the delayed level
    assign level_o = stage2_q;
    assign rise_o  = stage2_q & ~prev_q;
    assign fall_o  = ~stage2_q & prev_q;

endmodule

`default_nettype wire

// ---- verilog/hlpt_pkg.sv ----
package hlpt_pkg;

    // ------------------------------------------------------------------
    // widths
    // ------------------------------------------------------------------
    localparam int unsigned DATA_W  = 8;
    localparam int unsigned CNT_W   = 8;
    localparam int unsigned MODE_W  = 5;
    localparam int unsigned POST_W  = 4;
    localparam int unsigned PRE_W   = 7;
    localparam int unsigned PSEL_W  = 3;
    localparam int unsigned ADR_W   = 8;
    localparam int unsigned WB_W    = 32;

    // ------------------------------------------------------------------
    // register byte offsets
    // ------------------------------------------------------------------
    localparam logic [ADR_W-1:0] ADR_COUNT  = 8'h00;
    localparam logic [ADR_W-1:0] ADR_PERIOD = 8'h04;
    localparam logic [ADR_W-1:0] ADR_CTRL   = 8'h08;
    localparam logic [ADR_W-1:0] ADR_MODE   = 8'h0C;
    localparam logic [ADR_W-1:0] ADR_IRQ    = 8'h10;

    // ------------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------------
    localparam int unsigned CTRL_RUN_BIT  = 7;
    localparam int unsigned CTRL_PRE_MSB  = 6;
    localparam int unsigned CTRL_PRE_LSB  = 4;
    localparam int unsigned CTRL_POST_MSB = 3;
    localparam int unsigned CTRL_POST_LSB = 0;
    localparam int unsigned IRQ_EN_BIT    = 0;
    localparam int unsigned IRQ_FLAG_BIT  = 1;

    // ------------------------------------------------------------------
    // reset values and constants
    // ------------------------------------------------------------------
    localparam logic [CNT_W-1:0]  CNT_ZERO    = 8'h00;
    localparam logic [CNT_W-1:0]  CNT_ONE     = 8'h01;
    localparam logic [CNT_W-1:0]  PERIOD_RST  = 8'hFF;
    localparam logic [POST_W-1:0] POST_ZERO   = 4'h0;
    localparam logic [POST_W-1:0] POST_ONE    = 4'h1;
    localparam logic [PRE_W-1:0]  PRE_ZERO    = 7'h00;
    localparam logic [PRE_W-1:0]  PRE_ONE     = 7'h01;
    localparam logic [PRE_W-1:0]  PRE_FULL    = 7'h7F;
    localparam logic [PSEL_W-1:0] PRE_TOP     = 3'h7;
    localparam logic [DATA_W-1:0] DATA_ZERO   = 8'h00;

    // ------------------------------------------------------------------
    // mode codes
    // ------------------------------------------------------------------
    localparam logic [MODE_W-1:0] MODE_SW_GATE  = 5'h00;
    localparam logic [MODE_W-1:0] MODE_HW_GATEH = 5'h01;
    localparam logic [MODE_W-1:0] MODE_HW_GATEL = 5'h02;
    localparam logic [MODE_W-1:0] MODE_LIM_ANY  = 5'h03;
    localparam logic [MODE_W-1:0] MODE_LIM_RISE = 5'h04;
    localparam logic [MODE_W-1:0] MODE_LIM_FALL = 5'h05;
    localparam logic [MODE_W-1:0] MODE_LVL_LO   = 5'h06;
    localparam logic [MODE_W-1:0] MODE_LVL_HI   = 5'h07;
    localparam logic [MODE_W-1:0] MODE_OS_SW    = 5'h08;
    localparam logic [MODE_W-1:0] MODE_OS_RISE  = 5'h09;
    localparam logic [MODE_W-1:0] MODE_OS_FALL  = 5'h0A;
    localparam logic [MODE_W-1:0] MODE_OS_ANY   = 5'h0B;
    localparam logic [MODE_W-1:0] MODE_OSL_RISE = 5'h0C;
    localparam logic [MODE_W-1:0] MODE_OSL_FALL = 5'h0D;
    localparam logic [MODE_W-1:0] MODE_MS_RISE  = 5'h11;
    localparam logic [MODE_W-1:0] MODE_MS_FALL  = 5'h12;
    localparam logic [MODE_W-1:0] MODE_MS_ANY   = 5'h13;

    // start phase of the edge-started modes
    typedef enum logic [2:0] {
        PH_WAIT  = 3'b001,
        PH_COUNT = 3'b010,
        PH_HALT  = 3'b100
    } hlpt_phase_e;

endpackage

// ---- verilog/hlpt_postscaler.sv ----
`timescale 1ns/1ps
`default_nettype none

module hlpt_postscaler
    import hlpt_pkg::*;
(
    // clock and reset
    input  wire logic              clk_i,
    input  wire logic              rst_i,
    // control
    input  wire logic              clear_i,
    input  wire logic [POST_W-1:0] ratio_i,
    input  wire logic              match_i,
    // event out
    output logic                   fire_o
);

    logic [POST_W-1:0] cnt_q;
    logic              hit;

    // ratio field n means n+1 matches per event
    assign hit = match_i & (cnt_q == ratio_i);

    // match counter
    always_ff @(posedge clk_i) begin
        if (rst_i || clear_i) begin
            cnt_q <= POST_ZERO;
        end else if (hit) begin
            cnt_q <= POST_ZERO;
        end else if (match_i) begin
            cnt_q <= cnt_q + POST_ONE;
        end
    end

    assign fire_o = hit;

endmodule

`default_nettype wire

// ---- verilog/hlpt_timer.sv ----
// Decided for this implementation: register access over Wishbone and the register addresses.
`timescale 1ns/1ps
`default_nettype none

module hlpt_timer
    import hlpt_pkg::*;
(
    // clock and reset
    input  wire logic            clk_i,
    input  wire logic            rst_i,
    // wishbone slave
    input  wire logic            wb_cyc_i,
    input  wire logic            wb_stb_i,
    input  wire logic            wb_we_i,
    input  wire logic [ADR_W-1:0] wb_adr_i,
    input  wire logic [3:0]      wb_sel_i,
    input  wire logic [WB_W-1:0] wb_dat_i,
    output logic      [WB_W-1:0] wb_dat_o,
    output logic                 wb_ack_o,
    // external reset source and debug
    input  wire logic            ext_reset_signal_i,
    input  wire logic            freeze_i,
    // timer outputs
    output logic      [CNT_W-1:0] timer_count_o,
    output logic                 period_match_o,
    output logic                 irq_o
);

    // ------------------------------------------------------------------
    // functions
    // ------------------------------------------------------------------

    // edge that triggers the given mode
    function automatic logic trig_edge(input logic [MODE_W-1:0] mode,
                                       input logic rise, input logic fall);
        logic t;
        t = 1'b0;
        case (mode)
            MODE_LIM_ANY, MODE_OS_ANY, MODE_MS_ANY:      t = rise | fall;
            MODE_LIM_RISE, MODE_OS_RISE, MODE_OSL_RISE,
            MODE_MS_RISE:                                t = rise;
            MODE_LIM_FALL, MODE_OS_FALL, MODE_OSL_FALL,
            MODE_MS_FALL:                                t = fall;
            default:                                     t = 1'b0;
        endcase
        return t;
    endfunction

    // prescaler mask: ratio 2^sel
    function automatic logic [PRE_W-1:0] pre_mask(input logic [PSEL_W-1:0] sel);
        return PRE_FULL >> (PRE_TOP - sel);
    endfunction

    // ------------------------------------------------------------------
    // bus slave decode
    // ------------------------------------------------------------------
    logic             ack_q;
    logic [WB_W-1:0]  rdat_q;
    logic             req;
    logic             wr;
    logic             lane0;
    logic             wr_count;
    logic             wr_period;
    logic             wr_ctrl;
    logic             wr_mode;
    logic             wr_irq;
    logic [DATA_W-1:0] wdat;
    logic [DATA_W-1:0] rd_mux;

    // writes commit at the edge where ack is sampled high
    assign req       = wb_cyc_i & wb_stb_i;
    assign lane0     = wb_sel_i[0];
    assign wr        = req & wb_we_i & ack_q & lane0;
    assign wdat      = wb_dat_i[DATA_W-1:0];
    assign wr_count  = wr & (wb_adr_i == ADR_COUNT);
    assign wr_period = wr & (wb_adr_i == ADR_PERIOD);
    assign wr_ctrl   = wr & (wb_adr_i == ADR_CTRL);
    assign wr_mode   = wr & (wb_adr_i == ADR_MODE);
    assign wr_irq    = wr & (wb_adr_i == ADR_IRQ);

    // ------------------------------------------------------------------
    // registers
    // ------------------------------------------------------------------
    logic [CNT_W-1:0]  count_q;
    logic [CNT_W-1:0]  count_d;
    logic [CNT_W-1:0]  period_q;
    logic [CNT_W-1:0]  shadow_q;
    logic              run_q;
    logic              run_d;
    logic [PSEL_W-1:0] psel_q;
    logic [POST_W-1:0] post_q;
    logic [MODE_W-1:0] mode_q;
    logic              irq_en_q;
    logic              irq_flag_q;
    logic              irq_flag_d;
    logic [PRE_W-1:0]  pre_q;
    hlpt_phase_e       phase_q;
    hlpt_phase_e       phase_d;
    logic              match_q;
    logic              irq_q;

    // read multiplexer, unmapped reads zero
    assign rd_mux = (wb_adr_i == ADR_COUNT)  ? count_q :
                    (wb_adr_i == ADR_PERIOD) ? period_q :
                    (wb_adr_i == ADR_CTRL)   ? {run_q, psel_q, post_q} :
                    (wb_adr_i == ADR_MODE)   ? {{(DATA_W-MODE_W){1'b0}}, mode_q} :
                    (wb_adr_i == ADR_IRQ)    ? {6'h00, irq_flag_q, irq_en_q} :
                                               DATA_ZERO;

    // ack one cycle after request, dropped the cycle after
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_q  <= 1'b0;
            rdat_q <= 32'h0000_0000;
        end else begin
            ack_q <= req & ~ack_q;
            if (req && !ack_q) begin
                rdat_q <= {24'h00_0000, rd_mux};
            end
        end
    end

    // ------------------------------------------------------------------
    // external signal conditioning
    // ------------------------------------------------------------------
    logic ers_level;
    logic ers_rise;
    logic ers_fall;

    // delayed and freeze-gated external signal
    hlpt_ers_delay u_ers (
        .clk_i              (clk_i),
        .rst_i              (rst_i),
        .ext_reset_signal_i (ext_reset_signal_i),
        .freeze_i           (freeze_i),
        .level_o            (ers_level),
        .rise_o             (ers_rise),
        .fall_o             (ers_fall)
    );

    // ------------------------------------------------------------------
    // mode classes
    // ------------------------------------------------------------------
    logic is_gate;
    logic is_edge_lim;
    logic is_lvl_lim;
    logic is_os_sw;
    logic is_os_edge;
    logic is_os_lim;
    logic is_mono;
    logic is_valid;
    logic is_edge_start;
    logic is_one_shot;

    assign is_gate       = (mode_q == MODE_SW_GATE) | (mode_q == MODE_HW_GATEH) |
                           (mode_q == MODE_HW_GATEL);
    assign is_edge_lim   = (mode_q == MODE_LIM_ANY) | (mode_q == MODE_LIM_RISE) |
                           (mode_q == MODE_LIM_FALL);
    assign is_lvl_lim    = (mode_q == MODE_LVL_LO) | (mode_q == MODE_LVL_HI);
    assign is_os_sw      = (mode_q == MODE_OS_SW);
    assign is_os_edge    = (mode_q == MODE_OS_RISE) | (mode_q == MODE_OS_FALL) |
                           (mode_q == MODE_OS_ANY);
    assign is_os_lim     = (mode_q == MODE_OSL_RISE) | (mode_q == MODE_OSL_FALL);
    assign is_mono       = (mode_q == MODE_MS_RISE) | (mode_q == MODE_MS_FALL) |
                           (mode_q == MODE_MS_ANY);
    assign is_edge_start = is_os_edge | is_os_lim | is_mono;
    assign is_one_shot   = is_os_sw | is_os_edge | is_os_lim;
    assign is_valid      = is_gate | is_edge_lim | is_lvl_lim | is_one_shot | is_mono;

    // ------------------------------------------------------------------
    // trigger and gating terms
    // ------------------------------------------------------------------
    logic trig;
    logic start_edge;
    logic lvl_hold;
    logic gate_ok;
    logic started;
    logic count_en;
    logic tick;
    logic step;
    logic match;
    logic ext_rst;

    assign trig       = trig_edge(mode_q, ers_rise, ers_fall);
    assign started    = (phase_q == PH_COUNT);
    // a start edge counts only once run is set and not yet started
    assign start_edge = is_edge_start & run_q & trig & ~started;

    // level limit: reset level depends on the code, ignored when stopped
    assign lvl_hold   = is_lvl_lim & run_q &
                        (ers_level == (mode_q == MODE_LVL_HI));

    // hardware gate polarity
    assign gate_ok    = (mode_q == MODE_HW_GATEH) ? ers_level :
                        (mode_q == MODE_HW_GATEL) ? ~ers_level : 1'b1;

    // counting permission per mode class
    assign count_en   = (is_gate & run_q & gate_ok) |
                        (is_edge_lim & run_q) |
                        (is_lvl_lim & run_q & ~lvl_hold) |
                        (is_os_sw & run_q) |
                        (is_edge_start & run_q & started);

    // early resets from the external signal
    assign ext_rst    = (is_edge_lim & run_q & trig) |
                        (is_os_lim & run_q & started & trig) |
                        lvl_hold;

    // prescaler rollover and period compare against the shadow
    assign tick  = is_valid & ((pre_q & pre_mask(psel_q)) == pre_mask(psel_q));
    assign step  = is_valid & count_en & tick & ~ext_rst;
    assign match = step & (count_q == shadow_q);

    // ------------------------------------------------------------------
    // next-state terms
    // ------------------------------------------------------------------

    // count: write, external reset, period wrap, increment
    assign count_d = wr_count ? wdat :
                     ext_rst  ? CNT_ZERO :
                     match    ? CNT_ZERO :
                     step     ? count_q + CNT_ONE :
                                count_q;

    // run bit: software write wins, one-shot match clears it
    assign run_d = wr_ctrl ? wdat[CTRL_RUN_BIT] :
                   (match & is_one_shot) ? 1'b0 :
                   run_q;

    // phase of the edge-started modes
    always_comb begin
        phase_d = phase_q;
        case (phase_q)
            PH_WAIT: begin
                if (start_edge) begin
                    phase_d = PH_COUNT;
                end
            end
            PH_COUNT: begin
                if (match && is_mono) begin
                    phase_d = PH_HALT;
                end else if (match) begin
                    phase_d = PH_WAIT;
                end
            end
            PH_HALT: begin
                if (start_edge) begin
                    phase_d = PH_COUNT;
                end
            end
            default: begin
                phase_d = PH_WAIT;
            end
        endcase
        // stopping forgets the start, so a fresh edge is needed
        if (!run_q || !is_edge_start) begin
            phase_d = PH_WAIT;
        end
    end

    // sticky request flag, a new event beats a clear
    logic post_fire;

    assign irq_flag_d = post_fire ? 1'b1 :
                        (wr_irq & wdat[IRQ_FLAG_BIT]) ? 1'b0 :
                        irq_flag_q;

    // postscaler counts period matches
    hlpt_postscaler u_post (
        .clk_i   (clk_i),
        .rst_i   (rst_i),
        .clear_i (wr_ctrl),
        .ratio_i (post_q),
        .match_i (match),
        .fire_o  (post_fire)
    );

    // ------------------------------------------------------------------
    // timer state
    // ------------------------------------------------------------------

    // counter, run bit and phase
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            count_q <= CNT_ZERO;
            run_q   <= 1'b0;
            phase_q <= PH_WAIT;
        end else begin
            count_q <= count_d;
            run_q   <= run_d;
            phase_q <= phase_d;
        end
    end

    // prescaler, restarted by count or control writes
    always_ff @(posedge clk_i) begin
        if (rst_i || wr_count || wr_ctrl) begin
            pre_q <= PRE_ZERO;
        end else if (tick) begin
            pre_q <= PRE_ZERO;
        end else if (is_valid) begin
            pre_q <= pre_q + PRE_ONE;
        end
    end

    // period shadow reload events
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            shadow_q <= PERIOD_RST;
        end else if (wr_count || wr_ctrl || match || ext_rst) begin
            shadow_q <= period_q;
        end
    end

    // software registers
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            period_q <= PERIOD_RST;
            psel_q   <= 3'h0;
            post_q   <= POST_ZERO;
            mode_q   <= MODE_SW_GATE;
            irq_en_q <= 1'b0;
        end else begin
            if (wr_period) begin
                period_q <= wdat;
            end
            if (wr_ctrl) begin
                psel_q <= wdat[CTRL_PRE_MSB:CTRL_PRE_LSB];
                post_q <= wdat[CTRL_POST_MSB:CTRL_POST_LSB];
            end
            if (wr_mode) begin
                mode_q <= wdat[MODE_W-1:0];
            end
            if (wr_irq) begin
                irq_en_q <= wdat[IRQ_EN_BIT];
            end
        end
    end

    // flag and registered outputs
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            irq_flag_q <= 1'b0;
            match_q    <= 1'b0;
            irq_q      <= 1'b0;
        end else begin
            irq_flag_q <= irq_flag_d;
            match_q    <= match;
            irq_q      <= irq_flag_d & irq_en_q;
        end
    end

    // ------------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------------
    assign wb_ack_o       = ack_q;
    assign wb_dat_o       = rdat_q;
    assign timer_count_o  = count_q;
    assign period_match_o = match_q;
    assign irq_o          = irq_q;

endmodule

`default_nettype wire
